// ===== core/fstc_frame_start.sv
// frame start trigger control: registers, trigger selection and acquisition status
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "fstc_cfg.svh"

// Behaviour
// R1 - in waiting status each accepted trigger pulse starts one frame
// R2 - waiting status needs valid mode, begin command, and burst trigger if enabled
// R3 - trigger mode has two values: off internal, on external
// R4 - trigger mode off: all frame pulses generated inside, none needed from outside
// R5 - off and single frame: one internal pulse per begin command
// R6 - off and continuous: pulses from begin command until end command
// R7 - rate limit disabled: internal pulses at maximum permitted rate
// R8 - rate limit on and slower than maximum: pulses at programmed rate
// R9 - rate limit on and faster than maximum: pulses at maximum rate
// R10 - any frame pulse acts only in waiting status
// R11 - trigger mode off: exposure length from programmed exposure setting
// R12 - trigger on: source is soft command, soft signals 1-3, or lines 1,3,4
// R13 - host issues a soft trigger command per frame when soft source chosen
// R14 - host configures lines 3 and 4 as inputs before selecting them
// R15 - host picks edge; only rising or only falling edges trigger
// R16 - source selector resets to input line 1
// R17 - trigger on with soft source: exposure from programmed setting
// R18 - line 1 source: exposure from setting or from trigger pulse width
// R19 - leave waiting on exposure start, return once ready again
// R20 - pulses outside waiting status are dropped
// R21 - burst on: back to burst wait after burst length frames
// R22 - lines synchronised, edges give exactly one single-cycle pulse
module fstc_frame_start
  import fstc_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [`FSTC_ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0]       regWrData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [DATA_W-1:0]       regRdData,
  input  wire logic [2:0]              triggerLines,
  input  wire logic                    exposureBusy,
  output logic                         frame_begin_trigger,
  output logic                         exposureRun,
  output logic                         waitingFrame,
  output logic                         waitingBurst
);

  logic [DATA_W-1:0]       ctrl_r, ctrl_nxt;
  logic [`FSTC_SRC_W-1:0]  src_r, src_nxt;
  logic                    edge_r, edge_nxt;
  logic [DATA_W-1:0]       period_r, period_nxt;
  logic [DATA_W-1:0]       minPer_r, minPer_nxt;
  logic [DATA_W-1:0]       expo_r, expo_nxt;
  logic [DATA_W-1:0]       burst_r, burst_nxt;
  logic [DATA_W-1:0]       rdData_r, rdData_nxt;
  logic [DATA_W-1:0]       frames_r, frames_nxt;
  logic [DATA_W-1:0]       rateCnt_r, rateCnt_nxt;
  logic [DATA_W-1:0]       expCnt_r, expCnt_nxt;
  logic                    running_r, running_nxt;
  logic                    widthMode_r, widthMode_nxt;
  fstc_state_t             state_r, state_nxt;
  logic [2:0]              sync1_r;
  logic [2:0]              sync2_r;
  logic [2:0]              sync3_r;
  logic [2:0]              lineRiseAll;
  logic [2:0]              lineFallAll;
  logic [DATA_W-1:0]       cmd;
  logic                    extOn;
  logic                    contMode;
  logic                    rateEn;
  logic                    burstOn;
  logic                    modeOk;
  logic                    lineLevel;
  logic                    lineRise;
  logic                    lineFall;
  logic                    lineEdge;
  logic                    extPulse;
  logic                    intPulse;
  logic                    pulse;
  logic                    accept;
  logic [DATA_W-1:0]       effPeriod;

  assign cmd      = (regWrite && regAddr == `FSTC_REG_CMD) ? regWrData : `FSTC_ZERO;
  assign extOn    = ctrl_r[`FSTC_CTRL_EXTON];   // [R3]
  assign contMode = ctrl_r[`FSTC_CTRL_CONT];
  assign rateEn   = ctrl_r[`FSTC_CTRL_RATEEN];
  assign burstOn  = ctrl_r[`FSTC_CTRL_BURSTON];
  assign modeOk   = ctrl_r[`FSTC_CTRL_MODEOK];

  // two-flop synchroniser per line, third stage holds previous level for edges
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= triggerLines[gi];
          sync2_r[gi] <= sync1_r[gi];   // [R22]
          sync3_r[gi] <= sync2_r[gi];
        end
      end
      assign lineRiseAll[gi] = sync2_r[gi] & ~sync3_r[gi];   // [R22]
      assign lineFallAll[gi] = ~sync2_r[gi] & sync3_r[gi];
    end
  endgenerate

  // line index 0 is line 1, 1 is line 3, 2 is line 4
  always_comb begin
    lineLevel = 1'b0;
    lineRise  = 1'b0;
    lineFall  = 1'b0;
    if (src_r == `FSTC_SRC_LINE1) begin
      lineLevel = sync2_r[0];
      lineRise  = lineRiseAll[0];
      lineFall  = lineFallAll[0];
    end else if (src_r == `FSTC_SRC_LINE3) begin   // [R14]
      lineLevel = sync2_r[1];
      lineRise  = lineRiseAll[1];
      lineFall  = lineFallAll[1];
    end else if (src_r == `FSTC_SRC_LINE4) begin
      lineLevel = sync2_r[2];
      lineRise  = lineRiseAll[2];
      lineFall  = lineFallAll[2];
    end
  end

  assign lineEdge = (edge_r == `FSTC_EDGE_FALL) ? lineFall : lineRise;   // [R15] [R22]

  always_comb begin
    extPulse = 1'b0;
    case (src_r)   // [R12]
      `FSTC_SRC_SOFT:  extPulse = cmd[`FSTC_CMD_SOFT];   // [R13]
      `FSTC_SRC_SIG1:  extPulse = cmd[`FSTC_CMD_SIG1];
      `FSTC_SRC_SIG2:  extPulse = cmd[`FSTC_CMD_SIG2];
      `FSTC_SRC_SIG3:  extPulse = cmd[`FSTC_CMD_SIG3];
      `FSTC_SRC_LINE1: extPulse = lineEdge;
      `FSTC_SRC_LINE3: extPulse = lineEdge;
      `FSTC_SRC_LINE4: extPulse = lineEdge;
      default:         extPulse = 1'b0;
    endcase
  end

  // the minimum period stands for the maximum frame rate the settings allow
  always_comb begin
    effPeriod = minPer_r;   // [R7]
    if (rateEn && period_r > minPer_r) begin
      effPeriod = period_r;   // [R8]
    end   // a shorter programmed period falls back to the minimum [R9]
  end

  assign intPulse = running_r && (rateCnt_r == `FSTC_ZERO);   // [R4]
  assign pulse    = extOn ? extPulse : intPulse;   // [R3]
  assign accept   = pulse && (state_r == FSTC_WAIT);   // [R10] [R20]

  // register writes and run control
  always_comb begin
    ctrl_nxt    = ctrl_r;
    src_nxt     = src_r;
    edge_nxt    = edge_r;
    period_nxt  = period_r;
    minPer_nxt  = minPer_r;
    expo_nxt    = expo_r;
    burst_nxt   = burst_r;
    running_nxt = running_r;
    if (regWrite) begin
      if (regAddr == `FSTC_REG_CTRL) begin
        ctrl_nxt = regWrData;
      end else if (regAddr == `FSTC_REG_SRC) begin
        src_nxt  = regWrData[`FSTC_SRC_W-1:0];
        edge_nxt = regWrData[`FSTC_SRC_W];
      end else if (regAddr == `FSTC_REG_PERIOD) begin
        period_nxt = regWrData;
      end else if (regAddr == `FSTC_REG_MINPER) begin
        minPer_nxt = regWrData;
      end else if (regAddr == `FSTC_REG_EXPO) begin
        expo_nxt = regWrData;
      end else if (regAddr == `FSTC_REG_BURST) begin
        burst_nxt = regWrData;
      end
    end
    if (cmd[`FSTC_CMD_BEGIN] && modeOk) begin
      running_nxt = 1'b1;
    end else if (cmd[`FSTC_CMD_END]) begin
      running_nxt = 1'b0;   // [R6]
    end else if (!extOn && !contMode && intPulse && state_r == FSTC_WAIT) begin
      running_nxt = 1'b0;   // single frame: one pulse per begin command [R5]
    end
  end

  // internal pulse pacing: counter reloads on each accepted pulse
  always_comb begin
    rateCnt_nxt = rateCnt_r;
    if (!running_r) begin
      rateCnt_nxt = `FSTC_ZERO;
    end else if (accept) begin
      rateCnt_nxt = effPeriod - `FSTC_ONE;
    end else if (rateCnt_r != `FSTC_ZERO) begin
      rateCnt_nxt = rateCnt_r - `FSTC_ONE;
    end
  end

  // acquisition status
  always_comb begin
    state_nxt     = state_r;
    frames_nxt    = frames_r;
    expCnt_nxt    = expCnt_r;
    widthMode_nxt = widthMode_r;
    case (state_r)
      FSTC_IDLE: begin
        if (running_nxt && running_r) begin
          state_nxt  = burstOn ? FSTC_BURSTW : FSTC_WAIT;   // [R2]
          frames_nxt = `FSTC_ZERO;
        end
      end
      FSTC_BURSTW: begin
        if (cmd[`FSTC_CMD_BURST]) begin
          state_nxt  = FSTC_WAIT;   // [R2]
          frames_nxt = `FSTC_ZERO;
        end
      end
      FSTC_WAIT: begin
        if (accept) begin
          state_nxt  = FSTC_EXPOSE;   // [R1] [R19]
          frames_nxt = frames_r + `FSTC_ONE;
          expCnt_nxt = expo_r;   // [R11] [R17]
          widthMode_nxt = extOn && src_r == `FSTC_SRC_LINE1 && ctrl_r[`FSTC_CTRL_WIDTHEXP];   // [R18]
        end
      end
      FSTC_EXPOSE: begin
        if (widthMode_r) begin
          if (lineLevel == edge_r) begin
            state_nxt = FSTC_RECOVER;   // ends when line leaves active level [R18]
          end
        end else if (expCnt_r <= `FSTC_ONE) begin
          state_nxt = FSTC_RECOVER;
        end else begin
          expCnt_nxt = expCnt_r - `FSTC_ONE;
        end
      end
      FSTC_RECOVER: begin
        if (!exposureBusy) begin
          if (burstOn && frames_r >= burst_r) begin
            state_nxt = FSTC_BURSTW;   // [R21]
          end else begin
            state_nxt = FSTC_WAIT;   // [R19]
          end
        end
      end
      default: state_nxt = FSTC_IDLE;
    endcase
    if (!running_nxt && state_nxt == FSTC_WAIT) begin
      state_nxt = FSTC_IDLE;   // stop or finished single frame
    end else if (!running_r && state_r != FSTC_EXPOSE && state_r != FSTC_RECOVER) begin
      state_nxt = FSTC_IDLE;
    end
  end

  // read data for the cycle after the read strobe
  always_comb begin
    rdData_nxt = `FSTC_ZERO;
    if (regRead) begin
      if (regAddr == `FSTC_REG_CTRL) begin
        rdData_nxt = ctrl_r;
      end else if (regAddr == `FSTC_REG_SRC) begin
        rdData_nxt = {{(DATA_W-`FSTC_SRC_W-1){1'b0}}, edge_r, src_r};
      end else if (regAddr == `FSTC_REG_PERIOD) begin
        rdData_nxt = period_r;
      end else if (regAddr == `FSTC_REG_MINPER) begin
        rdData_nxt = minPer_r;
      end else if (regAddr == `FSTC_REG_EXPO) begin
        rdData_nxt = expo_r;
      end else if (regAddr == `FSTC_REG_BURST) begin
        rdData_nxt = burst_r;
      end else if (regAddr == `FSTC_REG_STATUS) begin
        rdData_nxt = {{(DATA_W-4){1'b0}}, running_r, state_r};
      end else if (regAddr == `FSTC_REG_COUNT) begin
        rdData_nxt = frames_r;
      end
    end
  end

  // configuration and run flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r      <= `FSTC_CTRL_RESET;
      src_r       <= `FSTC_SRC_RESET;   // [R16]
      edge_r      <= `FSTC_EDGE_RISE;
      period_r    <= `FSTC_PER_RESET;
      minPer_r    <= `FSTC_PER_RESET;
      expo_r      <= `FSTC_EXPO_RESET;
      burst_r     <= `FSTC_BURST_RESET;
      running_r   <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      src_r       <= src_nxt;
      edge_r      <= edge_nxt;
      period_r    <= period_nxt;
      minPer_r    <= minPer_nxt;
      expo_r      <= expo_nxt;
      burst_r     <= burst_nxt;
      running_r   <= running_nxt;
    end
  end

  // pulse pacing counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rateCnt_r   <= `FSTC_ZERO;
    end else begin
      rateCnt_r   <= rateCnt_nxt;
    end
  end

  // acquisition status and exposure timing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= FSTC_IDLE;
      frames_r    <= `FSTC_ZERO;
      expCnt_r    <= `FSTC_ZERO;
      widthMode_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      frames_r    <= frames_nxt;
      expCnt_r    <= expCnt_nxt;
      widthMode_r <= widthMode_nxt;
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r    <= `FSTC_ZERO;
    end else begin
      rdData_r    <= rdData_nxt;
    end
  end

  assign regRdData    = rdData_r;
  assign frame_begin_trigger   = accept;
  assign exposureRun  = (state_r == FSTC_EXPOSE);
  assign waitingFrame = (state_r == FSTC_WAIT);
  assign waitingBurst = (state_r == FSTC_BURSTW);

endmodule // fstc_frame_start

// ===== core/fstc_cfg.svh
// constants for the frame start trigger control block
`ifndef FSTC_CFG_SVH
`define FSTC_CFG_SVH
`define FSTC_SRC_W        3
`define FSTC_SRC_SOFT     3'h0
`define FSTC_SRC_SIG1     3'h1
`define FSTC_SRC_SIG2     3'h2
`define FSTC_SRC_SIG3     3'h3
`define FSTC_SRC_LINE1    3'h4
`define FSTC_SRC_LINE3    3'h5
`define FSTC_SRC_LINE4    3'h6
`define FSTC_SRC_RESET    3'h4
`define FSTC_EDGE_RISE    1'h0
`define FSTC_EDGE_FALL    1'h1
`define FSTC_ADDR_W       4
`define FSTC_REG_CTRL     4'h0
`define FSTC_REG_SRC      4'h1
`define FSTC_REG_PERIOD   4'h2
`define FSTC_REG_MINPER   4'h3
`define FSTC_REG_EXPO     4'h4
`define FSTC_REG_BURST    4'h5
`define FSTC_REG_CMD      4'h6
`define FSTC_REG_STATUS   4'h7
`define FSTC_REG_COUNT    4'h8
`define FSTC_CTRL_EXTON   0
`define FSTC_CTRL_CONT    1
`define FSTC_CTRL_RATEEN  2
`define FSTC_CTRL_BURSTON 3
`define FSTC_CTRL_WIDTHEXP 4
`define FSTC_CTRL_MODEOK  5
`define FSTC_CMD_BEGIN    0
`define FSTC_CMD_END      1
`define FSTC_CMD_SOFT     2
`define FSTC_CMD_SIG1     3
`define FSTC_CMD_SIG2     4
`define FSTC_CMD_SIG3     5
`define FSTC_CMD_BURST    6
`define FSTC_CTRL_RESET   32'h0000_0000
`define FSTC_PER_RESET    32'h0000_0001
`define FSTC_EXPO_RESET   32'h0000_0100
`define FSTC_BURST_RESET  32'h0000_0001
`define FSTC_ONE          32'h0000_0001
`define FSTC_ZERO         32'h0000_0000
`endif

// ===== core/fstc_pkg.sv
// types for the frame start trigger control block
package fstc_pkg;
  typedef enum logic [2:0] {
    FSTC_IDLE     = 3'b000,
    FSTC_BURSTW   = 3'b001,
    FSTC_WAIT     = 3'b010,
    FSTC_EXPOSE   = 3'b011,
    FSTC_RECOVER  = 3'b100
  } fstc_state_t;
endpackage

// ===== testbench/fstc_frame_start_monitor.sv
// assertion checker for the frame start trigger block
`timescale 1ns/100ps
`include "fstc_cfg.svh"
module fstc_frame_start_monitor #(parameter int DATA_W = 32) (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic [`FSTC_ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0]       regWrData,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [DATA_W-1:0]       regRdData,
  input wire logic [2:0]              triggerLines,
  input wire logic                    exposureBusy,
  input wire logic                    frame_begin_trigger,
  input wire logic                    exposureRun,
  input wire logic                    waitingFrame,
  input wire logic                    waitingBurst
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_accept;
    frame_begin_trigger && waitingFrame;
  endsequence
  sequence s_expose;
    exposureRun && !waitingFrame;
  endsequence
  // writes act one or two edges later, so quiet means no strobe now or one cycle ago
  a_start_in_wait: assert property (frame_begin_trigger |-> waitingFrame)
    else $error("start outside wait");
  a_start_exposes: assert property (s_accept |=> s_expose)
    else $error("no exposure after start");
  a_start_single: assert property (frame_begin_trigger |=> !frame_begin_trigger)
    else $error("start pulse too long");
  a_expose_cause: assert property ($rose(exposureRun) |-> $past(frame_begin_trigger))
    else $error("exposure without start");
  a_status_excl: assert property ($onehot0({exposureRun, waitingFrame, waitingBurst}))
    else $error("status flags overlap");
  a_rdata_quiet: assert property (!$past(regRead) |-> regRdData == '0)
    else $error("read data outside read");
  a_wait_holds: assert property (waitingFrame && !frame_begin_trigger && !regWrite && !$past(regWrite) |=> waitingFrame)
    else $error("wait left without start");
  a_burst_holds: assert property (waitingBurst && !regWrite && !$past(regWrite) |=> waitingBurst)
    else $error("burst wait left alone");
  a_busy_holds: assert property ($fell(exposureRun) && exposureBusy |=> !waitingFrame)
    else $error("wait entered while busy");
endmodule // fstc_frame_start_monitor

// ===== testbench/fstc_line_driver.sv
// trigger source and downstream stall model facing the frame start block
`timescale 1ns/100ps
module fstc_line_driver (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] fireLines,
  input  wire logic [7:0] pulseLen,
  input  wire logic [3:0] stallLen,
  input  wire logic       exposureRun,
  output logic      [2:0] triggerLines,
  output logic            exposureBusy
);
  logic [7:0] pulseCnt_r;
  logic [3:0] stallCnt_r;
  logic       runDly_r;
  // lines rest low; lines 3 and 4 are already set up as inputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt_r <= '0;
      stallCnt_r <= '0;
      runDly_r <= 1'b0;
      triggerLines <= '0;
    end else begin
      runDly_r <= exposureRun;
      if (fireLines != '0) begin
        triggerLines <= fireLines; // one rising and one falling edge per pulse
        pulseCnt_r <= pulseLen;
      end else if (pulseCnt_r > 8'h01) begin
        pulseCnt_r <= pulseCnt_r - 8'h01;
      end else begin
        triggerLines <= '0;
      end
      if (runDly_r && !exposureRun) begin
        stallCnt_r <= stallLen;
      end else if (stallCnt_r != '0) begin
        stallCnt_r <= stallCnt_r - 4'h1;
      end
    end
  end
  // downstream stays busy a little past each exposure, delaying the return to wait
  assign exposureBusy = exposureRun || runDly_r || (stallCnt_r != '0);
endmodule // fstc_line_driver

// ===== testbench/tb_fstc_frame_start.sv
// self-checking bench for the frame start trigger block
`timescale 1ns/100ps
`include "fstc_cfg.svh"
`define CHK(g, e) begin \
  checksDone++; \
  if ((g) !== (e)) begin \
    nFail++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_fstc_frame_start;
  logic        clk = 0, arst_n = 0, regWrite = 0, regRead = 0;
  logic        frame_begin_trigger, exposureRun, waitingFrame, waitingBurst, exposureBusy;
  logic [3:0]  regAddr = 4'h0, stallLen = 4'h0;
  logic [31:0] regWrData = 32'h0000_0000, regRdData, rnd = 32'h0000_d6c9;
  logic [2:0]  triggerLines, fireLines = 3'h0;
  logic [7:0]  pulseLen = 8'h0c;
  int          nFail, checksDone, cyc, lastT, gap, starts, runCnt, lastExp, k, n, m, p, s, e;
  always #2 clk = ~clk;
  fstc_frame_start #(.DATA_W(32)) u_fstc_frame_start (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .triggerLines(triggerLines), .exposureBusy(exposureBusy), .frame_begin_trigger(frame_begin_trigger),
    .exposureRun(exposureRun), .waitingFrame(waitingFrame), .waitingBurst(waitingBurst));
  fstc_line_driver u_fstc_line_driver (.clk(clk), .arst_n(arst_n), .fireLines(fireLines), .pulseLen(pulseLen),
    .stallLen(stallLen), .exposureRun(exposureRun), .triggerLines(triggerLines), .exposureBusy(exposureBusy));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // the slower of the floor period and the enabled programmed period wins
  function automatic int spacing(bit en, int mn, int pr);
    return (en && pr > mn) ? pr : mn;
  endfunction
  task automatic finalReport();
    if (nFail == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] x);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 `CHK(regRdData, x)
  endtask
  task automatic waitStarts(int t);
    for (int i = 0; i < 400 && starts < t; i++) @(posedge clk);
    if (starts < t) begin
      nFail++;
      finalReport();
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (frame_begin_trigger) begin
      gap = cyc - lastT;
      lastT = cyc;
      starts++;
    end
    if (exposureRun) runCnt++;
    else if (runCnt > 0) begin
      lastExp = runCnt;
      runCnt = 0;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(`FSTC_REG_SRC, 32'h0000_0004);
    rd(`FSTC_REG_EXPO, `FSTC_EXPO_RESET);
    rd(`FSTC_REG_STATUS, 32'h0000_0000);
    rd(4'hf, 32'h0000_0000);
    wr(`FSTC_REG_CMD, 32'h0000_0001);
    repeat (4) @(posedge clk);
    #1 `CHK(waitingFrame, 1'b0)
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      stallLen <= {2'b00, rnd[13:12]};
      wr(`FSTC_REG_EXPO, 2 + rnd[2:0]);
      wr(`FSTC_REG_CTRL, 32'h0000_0020);
      n = starts;
      wr(`FSTC_REG_CMD, 32'h0000_0001);
      waitStarts(n + 1);
      repeat (40) @(posedge clk);
      #1 `CHK(starts, n + 1)
      `CHK(lastExp, 2 + rnd[2:0])
    end
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      m = 16 + rnd[3:0];
      p = (k == 2) ? m - 1 - rnd[5:4] : m + 1 + rnd[9:6];
      wr(`FSTC_REG_EXPO, 32'h0000_0003);
      wr(`FSTC_REG_MINPER, m);
      wr(`FSTC_REG_PERIOD, p);
      wr(`FSTC_REG_CTRL, k ? 32'h0000_0026 : 32'h0000_0022);
      wr(`FSTC_REG_CMD, 32'h0000_0001);
      waitStarts(starts + 3);
      #1 `CHK(gap, spacing(k > 0, m, p))
      wr(`FSTC_REG_CMD, 32'h0000_0002);
      repeat (8) @(posedge clk);
      n = starts;
      repeat (80) @(posedge clk);
      #1 `CHK(starts, n)
    end
    wr(`FSTC_REG_EXPO, 32'h0000_0004);
    for (k = 0; k < 14; k++) begin
      s = k % 7;
      e = k / 7;
      wr(`FSTC_REG_SRC, (e << 3) | s);
      wr(`FSTC_REG_CTRL, 32'h0000_0023);
      wr(`FSTC_REG_CMD, 32'h0000_0001);
      repeat (4) @(posedge clk);
      n = starts;
      if (s < 4) begin
        wr(`FSTC_REG_CMD, 4 << s);
        wr(`FSTC_REG_CMD, 4 << s);
      end else begin
        fireLines <= ~(3'h1 << (s - 4));
        @(posedge clk);
        fireLines <= 3'h0;
        repeat (30) @(posedge clk);
        #1 `CHK(starts, n)
        fireLines <= 3'h1 << (s - 4);
        @(posedge clk);
        fireLines <= 3'h0;
        repeat (8) @(posedge clk);
        #1 `CHK(starts, n + 1 - e)
      end
      repeat (30) @(posedge clk);
      #1 `CHK(starts, n + 1)
      `CHK(lastExp, 4)
      wr(`FSTC_REG_CMD, 32'h0000_0002);
      repeat (10) @(posedge clk);
    end
    // line 1 rising, exposure follows the pulse width
    rnd = lfsr(rnd);
    pulseLen <= 8'h04 + {4'h0, rnd[3:0]};
    wr(`FSTC_REG_SRC, 32'h0000_0004);
    wr(`FSTC_REG_CTRL, 32'h0000_0033);
    wr(`FSTC_REG_CMD, 32'h0000_0001);
    repeat (4) @(posedge clk);
    n = starts;
    fireLines <= 3'h1;
    @(posedge clk);
    fireLines <= 3'h0;
    repeat (40) @(posedge clk);
    #1 `CHK(starts, n + 1)
    `CHK(lastExp, pulseLen)
    wr(`FSTC_REG_CMD, 32'h0000_0002);
    repeat (10) @(posedge clk);
    wr(`FSTC_REG_SRC, 32'h0000_0000);
    wr(`FSTC_REG_BURST, 32'h0000_0002);
    wr(`FSTC_REG_CTRL, 32'h0000_002b);
    wr(`FSTC_REG_CMD, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1 `CHK(waitingBurst, 1'b1)
    n = starts;
    wr(`FSTC_REG_CMD, 32'h0000_0004);
    repeat (10) @(posedge clk);
    #1 `CHK(starts, n)
    wr(`FSTC_REG_CMD, 32'h0000_0040);
    repeat (3) @(posedge clk);
    #1 `CHK(waitingFrame, 1'b1)
    repeat (2) begin
      wr(`FSTC_REG_CMD, 32'h0000_0004);
      repeat (20) @(posedge clk);
    end
    #1 `CHK(starts, n + 2)
    `CHK(waitingBurst, 1'b1)
    rd(`FSTC_REG_COUNT, 32'h0000_0002);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(`FSTC_REG_SRC, 32'h0000_0004);
    rd(`FSTC_REG_CTRL, `FSTC_CTRL_RESET);
    #1 `CHK(waitingBurst, 1'b0)
    finalReport();
  end
endmodule // tb_fstc_frame_start
bind fstc_frame_start fstc_frame_start_monitor #(.DATA_W(DATA_W)) u_fstc_frame_start_monitor (.clk(clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .triggerLines(triggerLines), .exposureBusy(exposureBusy), .frame_begin_trigger(frame_begin_trigger),
  .exposureRun(exposureRun), .waitingFrame(waitingFrame), .waitingBurst(waitingBurst));
